// ==== include/crxsc_pkg.sv ====
`default_nettype none

package crxsc_pkg;

    // Geometry of the receive shift register
    localparam int unsigned CRXSC_BYTES = 4;
    localparam int unsigned CRXSC_BYTE_W = 8;
    localparam int unsigned CRXSC_WORD_W = 32;

    // Field widths taken out of the shift register, and the buffer word index width
    localparam int unsigned CRXSC_BASE_ID_W = 11;
    localparam int unsigned CRXSC_EXT_ID_W = 18;
    localparam int unsigned CRXSC_DLC_W = 4;
    localparam int unsigned CRXSC_STUFF_W = 4;
    localparam int unsigned CRXSC_WORD_IDX_W = 4;

    // Register bus geometry
    localparam int unsigned CRXSC_ADR_W = 8;

    // Register byte offsets
    localparam logic [7:0] CRXSC_OFS_CTRL = 8'h00;
    localparam logic [7:0] CRXSC_OFS_STATUS = 8'h04;
    localparam logic [7:0] CRXSC_OFS_BASE_ID = 8'h08;
    localparam logic [7:0] CRXSC_OFS_EXT_ID = 8'h0C;
    localparam logic [7:0] CRXSC_OFS_META = 8'h10;
    localparam logic [7:0] CRXSC_OFS_SHIFT = 8'h14;

    // Control register fields
    localparam int unsigned CRXSC_CTRL_ENABLE_BIT = 0;
    localparam int unsigned CRXSC_CTRL_CLEAR_BIT = 1;
    localparam logic CRXSC_CTRL_ENABLE_RST = 1'b1;

    // Status register fields
    localparam int unsigned CRXSC_ST_HOLD_BIT = 0;
    localparam int unsigned CRXSC_ST_BRS_BIT = 1;
    localparam int unsigned CRXSC_ST_ESI_BIT = 2;
    localparam int unsigned CRXSC_ST_IDFMT_BIT = 3;
    localparam int unsigned CRXSC_ST_RTR_BIT = 4;
    localparam int unsigned CRXSC_ST_FRFMT_BIT = 5;
    localparam int unsigned CRXSC_ST_WIDX_LSB = 8;

    // Metadata register fields
    localparam int unsigned CRXSC_META_DLC_LSB = 0;
    localparam int unsigned CRXSC_META_STUFF_LSB = 8;

    // Shift word value loaded by software clear, and read data for unmapped offsets
    localparam logic [31:0] CRXSC_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] CRXSC_READ_UNMAPPED = 32'h0000_0000;

endpackage

`default_nettype wire

// ==== verilog/crxsc_rx_shift.sv ====
`default_nettype none

module crxsc_rx_shift
    import crxsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rxBit,
    input wire logic bitProcess,
    input wire logic [CRXSC_BYTES-1:0] byteShiftEn,
    input wire logic linearMode,
    input wire logic storeBaseId,
    input wire logic storeExtId,
    input wire logic storeDlc,
    input wire logic storeDataWord,
    input wire logic storeStuffCount,
    input wire logic crcFieldEnd,
    input wire logic frameStart,
    input wire logic captureBrs,
    input wire logic captureEsi,
    input wire logic captureIde,
    input wire logic captureRtr,
    input wire logic captureEdl,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CRXSC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [CRXSC_WORD_W-1:0] rxShiftWord,
    output logic [CRXSC_BASE_ID_W-1:0] baseIdCapture,
    output logic [CRXSC_EXT_ID_W-1:0] extIdCapture,
    output logic [CRXSC_DLC_W-1:0] dlcCapture,
    output logic [CRXSC_STUFF_W-1:0] stuffCountCapture,
    output logic bitRateSwitchFlag,
    output logic errorStateFlag,
    output logic identifier_format_flag,
    output logic remoteRequestFlag,
    output logic frame_format_flag,
    output logic rxBufWrite,
    output logic [CRXSC_WORD_W-1:0] rxBufData,
    output logic [CRXSC_WORD_IDX_W-1:0] rxBufWordIdx
);

    typedef struct packed {
        logic [CRXSC_WORD_W-1:0] shiftWord;
        logic [CRXSC_BASE_ID_W-1:0] baseId;
        logic [CRXSC_EXT_ID_W-1:0] extId;
        logic [CRXSC_DLC_W-1:0] dlc;
        logic [CRXSC_STUFF_W-1:0] stuffCount;
        logic brs;
        logic esi;
        logic idFormat;
        logic rtr;
        logic frFormat;
        logic hold;
        logic bufWrite;
        logic [CRXSC_WORD_W-1:0] bufData;
        logic [CRXSC_WORD_IDX_W-1:0] wordIdx;
        logic ctrlEnable;
        logic wbAck;
        logic [31:0] wbData;
    } crxsc_state_s;

    crxsc_state_s state_reg;
    crxsc_state_s state_next;

    logic shiftAllowed;
    // A net, because each byte slice has its own driver
    wire logic [CRXSC_WORD_W-1:0] shiftedWord;
    logic wbRequest;
    logic wbWrite;
    logic softClear;

    function automatic logic crxsc_hit(input logic [CRXSC_ADR_W-1:0] adr, input logic [7:0] ofs);
        crxsc_hit = (adr == ofs);
    endfunction

    // The state machine keeps the enables quiet outside fields; the hold flag
    // is a second guard so the CRC cannot be disturbed by a stray enable.
    assign shiftAllowed = bitProcess && !state_reg.hold && state_reg.ctrlEnable;

    genvar gi;
    generate
        for (gi = 0; gi < CRXSC_BYTES; gi++) begin : g_byte
            logic byteIn;
            logic [CRXSC_BYTE_W-1:0] byteNext;
            if (gi == 0) begin : g_first
                assign byteIn = rxBit;
            end else begin : g_chain
                // Previous byte's top bit in linear mode, serial input in byte mode
                assign byteIn = linearMode ? state_reg.shiftWord[gi*CRXSC_BYTE_W-1] : rxBit;
            end
            always_comb begin
                if (shiftAllowed && byteShiftEn[gi]) begin
                    byteNext = {state_reg.shiftWord[gi*CRXSC_BYTE_W +: CRXSC_BYTE_W-1], byteIn};
                end else begin
                    byteNext = state_reg.shiftWord[gi*CRXSC_BYTE_W +: CRXSC_BYTE_W];
                end
            end
            assign shiftedWord[gi*CRXSC_BYTE_W +: CRXSC_BYTE_W] = byteNext;
        end
    endgenerate

    assign wbRequest = wb_cyc_i && wb_stb_i && !state_reg.wbAck;
    assign wbWrite = wbRequest && wb_we_i;
    assign softClear = wbWrite && crxsc_hit(wb_adr_i, CRXSC_OFS_CTRL) && wb_sel_i[0] &&
        wb_dat_i[CRXSC_CTRL_CLEAR_BIT];

    always_comb begin
        state_next = state_reg;
        state_next.bufWrite = 1'b0;

        // Software clear comes first so that a capture in the same cycle wins
        if (softClear) begin
            state_next.shiftWord = CRXSC_WORD_RST;
            state_next.baseId = '0;
            state_next.extId = '0;
            state_next.dlc = '0;
            state_next.stuffCount = '0;
            state_next.brs = 1'b0;
            state_next.esi = 1'b0;
            state_next.idFormat = 1'b0;
            state_next.rtr = 1'b0;
            state_next.frFormat = 1'b0;
            state_next.wordIdx = '0;
        end else begin
            state_next.shiftWord = shiftedWord;
        end

        if (frameStart) begin
            state_next.hold = 1'b0;
            state_next.wordIdx = '0;
        end else if (crcFieldEnd && bitProcess) begin
            state_next.hold = 1'b1;
        end

        // Stores see the word including the bit that ends the field
        if (storeBaseId) begin
            state_next.baseId = shiftedWord[CRXSC_BASE_ID_W-1:0];
        end
        if (storeExtId) begin
            state_next.extId = shiftedWord[CRXSC_EXT_ID_W-1:0];
        end
        if (storeDlc) begin
            state_next.dlc = shiftedWord[CRXSC_DLC_W-1:0];
        end
        if (storeStuffCount) begin
            state_next.stuffCount = shiftedWord[CRXSC_STUFF_W-1:0];
        end
        if (storeDataWord) begin
            state_next.bufWrite = 1'b1;
            state_next.bufData = shiftedWord;
        end
        // Index of the word now being written; wraps after the largest payload
        if (state_reg.bufWrite && !frameStart) begin
            state_next.wordIdx = state_reg.wordIdx + 1'b1;
        end

        if (captureBrs) begin
            state_next.brs = rxBit;
        end
        if (captureEsi) begin
            state_next.esi = rxBit;
        end
        if (captureIde) begin
            state_next.idFormat = rxBit;
        end
        if (captureRtr) begin
            state_next.rtr = rxBit;
        end
        if (captureEdl) begin
            state_next.frFormat = rxBit;
        end

        // Classic single-cycle slave: ack one cycle after the strobe, then drops
        state_next.wbAck = wbRequest;
        state_next.wbData = CRXSC_READ_UNMAPPED;
        if (wbWrite && crxsc_hit(wb_adr_i, CRXSC_OFS_CTRL) && wb_sel_i[0]) begin
            state_next.ctrlEnable = wb_dat_i[CRXSC_CTRL_ENABLE_BIT];
        end
        if (wbRequest && !wb_we_i) begin
            unique case (wb_adr_i)
                CRXSC_OFS_CTRL: begin
                    state_next.wbData[CRXSC_CTRL_ENABLE_BIT] = state_reg.ctrlEnable;
                end
                CRXSC_OFS_STATUS: begin
                    state_next.wbData[CRXSC_ST_HOLD_BIT] = state_reg.hold;
                    state_next.wbData[CRXSC_ST_BRS_BIT] = state_reg.brs;
                    state_next.wbData[CRXSC_ST_ESI_BIT] = state_reg.esi;
                    state_next.wbData[CRXSC_ST_IDFMT_BIT] = state_reg.idFormat;
                    state_next.wbData[CRXSC_ST_RTR_BIT] = state_reg.rtr;
                    state_next.wbData[CRXSC_ST_FRFMT_BIT] = state_reg.frFormat;
                    state_next.wbData[CRXSC_ST_WIDX_LSB +: CRXSC_WORD_IDX_W] = state_reg.wordIdx;
                end
                CRXSC_OFS_BASE_ID: begin
                    state_next.wbData[CRXSC_BASE_ID_W-1:0] = state_reg.baseId;
                end
                CRXSC_OFS_EXT_ID: begin
                    state_next.wbData[CRXSC_EXT_ID_W-1:0] = state_reg.extId;
                end
                CRXSC_OFS_META: begin
                    state_next.wbData[CRXSC_META_DLC_LSB +: CRXSC_DLC_W] = state_reg.dlc;
                    state_next.wbData[CRXSC_META_STUFF_LSB +: CRXSC_STUFF_W] = state_reg.stuffCount;
                end
                CRXSC_OFS_SHIFT: begin
                    state_next.wbData = state_reg.shiftWord;
                end
                default: begin
                    state_next.wbData = CRXSC_READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.ctrlEnable <= CRXSC_CTRL_ENABLE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rxShiftWord = state_reg.shiftWord;
    assign baseIdCapture = state_reg.baseId;
    assign extIdCapture = state_reg.extId;
    assign dlcCapture = state_reg.dlc;
    assign stuffCountCapture = state_reg.stuffCount;
    assign bitRateSwitchFlag = state_reg.brs;
    assign errorStateFlag = state_reg.esi;
    assign identifier_format_flag = state_reg.idFormat;
    assign remoteRequestFlag = state_reg.rtr;
    assign frame_format_flag = state_reg.frFormat;
    assign rxBufWrite = state_reg.bufWrite;
    assign rxBufData = state_reg.bufData;
    assign rxBufWordIdx = state_reg.wordIdx;
    assign wb_dat_o = state_reg.wbData;
    assign wb_ack_o = state_reg.wbAck;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_bit_taken;
        bitProcess && !state_reg.hold && state_reg.ctrlEnable && !softClear;
    endsequence

    sequence s_linear_all;
        linearMode && (byteShiftEn == 4'hF);
    endsequence

    property p_linear_shift;
        s_bit_taken and s_linear_all |=>
            rxShiftWord == {$past(rxShiftWord[30:0]), $past(rxBit)};
    endproperty
    a_linear_shift: assert property (p_linear_shift) else $error("linear shift wrong");

    property p_byte0_only;
        s_bit_taken and (!linearMode && byteShiftEn == 4'h1) |=>
            rxShiftWord[31:8] == $past(rxShiftWord[31:8]) &&
            rxShiftWord[7:0] == {$past(rxShiftWord[6:0]), $past(rxBit)};
    endproperty
    a_byte0_only: assert property (p_byte0_only) else $error("byte mode byte 0 wrong");

    property p_byte2_serial;
        s_bit_taken and (!linearMode && byteShiftEn == 4'h4) |=>
            rxShiftWord[16] == $past(rxBit) && rxShiftWord[7:0] == $past(rxShiftWord[7:0]);
    endproperty
    a_byte2_serial: assert property (p_byte2_serial) else $error("byte mode input not serial");

    property p_hold_stable;
        state_reg.hold && !frameStart && !softClear |=> $stable(rxShiftWord);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("shift after CRC field");

    property p_hold_set;
        crcFieldEnd && bitProcess && !frameStart |=> state_reg.hold;
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("hold not set after CRC");

    property p_base_id;
        storeBaseId && !softClear |=> baseIdCapture == rxShiftWord[CRXSC_BASE_ID_W-1:0];
    endproperty
    a_base_id: assert property (p_base_id) else $error("base identifier capture wrong");

    property p_no_store;
        !storeBaseId && !softClear |=> $stable(baseIdCapture);
    endproperty
    a_no_store: assert property (p_no_store) else $error("base identifier changed without store");

    property p_dlc;
        storeDlc |=> dlcCapture == rxShiftWord[CRXSC_DLC_W-1:0];
    endproperty
    a_dlc: assert property (p_dlc) else $error("length code capture wrong");

    property p_stuff;
        storeStuffCount |=> stuffCountCapture == rxShiftWord[CRXSC_STUFF_W-1:0];
    endproperty
    a_stuff: assert property (p_stuff) else $error("stuff count capture wrong");

    property p_buf_write;
        storeDataWord |=> rxBufWrite && rxBufData == rxShiftWord;
    endproperty
    a_buf_write: assert property (p_buf_write) else $error("data word not written");

    property p_ide_flag;
        captureIde |=> identifier_format_flag == $past(rxBit);
    endproperty
    a_ide_flag: assert property (p_ide_flag) else $error("identifier format flag wrong");

    property p_brs_flag;
        captureBrs ##1 !captureBrs [*2] |-> bitRateSwitchFlag == $past(rxBit, 2);
    endproperty
    a_brs_flag: assert property (p_brs_flag) else $error("bit rate switch flag wrong");

    property p_esi_flag;
        captureEsi |=> errorStateFlag == $past(rxBit);
    endproperty
    a_esi_flag: assert property (p_esi_flag) else $error("error state flag wrong");

    property p_rtr_flag;
        captureRtr |=> remoteRequestFlag == $past(rxBit);
    endproperty
    a_rtr_flag: assert property (p_rtr_flag) else $error("remote request flag wrong");

    property p_edl_flag;
        captureEdl |=> frame_format_flag == $past(rxBit);
    endproperty
    a_edl_flag: assert property (p_edl_flag) else $error("frame format flag wrong");

    property p_ext_id;
        storeExtId && !softClear |=> extIdCapture == rxShiftWord[CRXSC_EXT_ID_W-1:0];
    endproperty
    a_ext_id: assert property (p_ext_id) else $error("extended identifier capture wrong");

    // A buffer write stands for exactly one cycle per store command
    property p_buf_pulse;
        !storeDataWord |=> !rxBufWrite;
    endproperty
    a_buf_pulse: assert property (p_buf_pulse) else $error("buffer write not a single pulse");

    property p_word_idx;
        rxBufWrite && !frameStart |=> rxBufWordIdx == $past(rxBufWordIdx) + 4'h1;
    endproperty
    a_word_idx: assert property (p_word_idx) else $error("buffer word index not advanced");

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    property p_wb_ack;
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

endmodule

`default_nettype wire

// ==== dv/crxsc_proto_model.sv ====
`default_nettype none

module crxsc_proto_model
    import crxsc_pkg::*;
(
    input wire logic ref_clk,
    output logic rxBit,
    output logic bitProcess,
    output logic [CRXSC_BYTES-1:0] byteShiftEn,
    output logic linearMode,
    output logic storeBaseId,
    output logic storeExtId,
    output logic storeDlc,
    output logic storeDataWord,
    output logic storeStuffCount,
    output logic crcFieldEnd,
    output logic frameStart,
    output logic [4:0] capt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Between bits the line shows the inverse, so a stray sample is caught
    task automatic idle(input logic b);
        bitProcess <= 1'b0;
        storeBaseId <= 1'b0;
        storeExtId <= 1'b0;
        storeDlc <= 1'b0;
        storeDataWord <= 1'b0;
        storeStuffCount <= 1'b0;
        crcFieldEnd <= 1'b0;
        frameStart <= 1'b0;
        capt <= 5'h00;
        rxBit <= b;
    endtask

    initial begin
        linearMode <= 1'b1;
        byteShiftEn <= 4'h0;
        idle(1'b0);
    end

    // Sends n bits MSB first; gap idle cycles stretch the bit time
    task automatic field(input logic [31:0] v, input int n, input logic lin, input logic [3:0] en,
                         input int st, input int gap);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk);
            rxBit <= v[i];
            bitProcess <= 1'b1;
            linearMode <= lin;
            byteShiftEn <= en;
            storeBaseId <= i == 0 && st == 1;
            storeExtId <= i == 0 && st == 2;
            storeDlc <= i == 0 && st == 3;
            storeStuffCount <= i == 0 && st == 4;
            crcFieldEnd <= i == 0 && st == 5;
            storeDataWord <= i == 0 && st == 6;
            repeat (gap) begin
                @(posedge ref_clk);
                idle(~v[i]);
            end
        end
        @(posedge ref_clk);
        idle(~rxBit);
    endtask

    // k: 0 brs, 1 esi, 2 identifier extension, 3 remote request, 4 extended length
    task automatic flag(input int k, input logic b);
        @(posedge ref_clk);
        rxBit <= b;
        capt <= 5'(5'h10 >> k);
        @(posedge ref_clk);
        idle(~b);
    endtask

    task automatic sof();
        @(posedge ref_clk);
        frameStart <= 1'b1;
        @(posedge ref_clk);
        idle(1'b0);
    endtask
endmodule

`default_nettype wire

// ==== dv/test_can_rx_field_shift_capture.sv ====
`default_nettype none

module test_can_rx_field_shift_capture
    import crxsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDat = 32'h0000_0000;
    logic [31:0] wbDatO, rxShiftWord, rxBufData;
    logic wbAck, rxBit, bitProcess, linearMode, storeBaseId, storeExtId, storeDlc, storeDataWord;
    logic storeStuffCount, crcFieldEnd, frameStart, rxBufWrite;
    logic [3:0] byteShiftEn, dlcCapture, stuffCountCapture, rxBufWordIdx;
    logic [4:0] capt, fl;
    logic [10:0] baseIdCapture;
    logic [17:0] extIdCapture;
    int badCount = 0;
    int numChecks = 0;

    always #2 ref_clk = ~ref_clk;

    crxsc_proto_model u_crxsc_proto_model (.ref_clk(ref_clk), .rxBit(rxBit), .bitProcess(bitProcess),
        .byteShiftEn(byteShiftEn), .linearMode(linearMode), .storeBaseId(storeBaseId),
        .storeExtId(storeExtId), .storeDlc(storeDlc), .storeDataWord(storeDataWord),
        .storeStuffCount(storeStuffCount), .crcFieldEnd(crcFieldEnd), .frameStart(frameStart), .capt(capt));

    crxsc_rx_shift u_crxsc_rx_shift (.ref_clk(ref_clk), .rst_n(rst_n), .rxBit(rxBit), .bitProcess(bitProcess),
        .byteShiftEn(byteShiftEn), .linearMode(linearMode), .storeBaseId(storeBaseId),
        .storeExtId(storeExtId), .storeDlc(storeDlc), .storeDataWord(storeDataWord),
        .storeStuffCount(storeStuffCount), .crcFieldEnd(crcFieldEnd), .frameStart(frameStart),
        .captureBrs(capt[4]), .captureEsi(capt[3]), .captureIde(capt[2]), .captureRtr(capt[1]),
        .captureEdl(capt[0]), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .rxShiftWord(rxShiftWord),
        .baseIdCapture(baseIdCapture), .extIdCapture(extIdCapture), .dlcCapture(dlcCapture),
        .stuffCountCapture(stuffCountCapture), .bitRateSwitchFlag(fl[4]), .errorStateFlag(fl[3]),
        .identifier_format_flag(fl[2]), .remoteRequestFlag(fl[1]), .frame_format_flag(fl[0]),
        .rxBufWrite(rxBufWrite), .rxBufData(rxBufData), .rxBufWordIdx(rxBufWordIdx));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic printVerdict();
        if (badCount == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One classic cycle; e is the expected read data
    task automatic wbGo(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 40);
        if (n >= 40) begin
            badCount++;
            printVerdict();
        end
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (!we)
            chk("rdata", e, wbDatO);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        wbGo(1'b0, CRXSC_OFS_CTRL, 32'h0, 32'h1);
        wbGo(1'b0, CRXSC_OFS_STATUS, 32'h0, 32'h0);
        wbGo(1'b0, CRXSC_OFS_SHIFT, 32'h0, 32'h0);
        wbGo(1'b0, 8'h40, 32'h0, CRXSC_READ_UNMAPPED);
        u_crxsc_proto_model.sof();
        u_crxsc_proto_model.field(32'h123, 11, 1'b1, 4'hF, 1, 0);
        @(posedge ref_clk);
        chk("baseId", 32'h123, 32'(baseIdCapture));
        chk("shift", 32'h123, rxShiftWord);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++)
                u_crxsc_proto_model.flag(k, 1'((k + p) % 2 == 0));
            @(posedge ref_clk);
            chk("flags", (p != 0) ? 32'h0A : 32'h15, 32'(fl));
        end
        u_crxsc_proto_model.field(32'h2ABCD, 18, 1'b1, 4'hF, 2, 3);
        @(posedge ref_clk);
        chk("extId", 32'h2ABCD, 32'(extIdCapture));
        chk("shift", 32'h048EABCD, rxShiftWord);
        u_crxsc_proto_model.field(32'h2, 4, 1'b1, 4'hF, 3, 0);
        @(posedge ref_clk);
        chk("dlc", 32'h2, 32'(dlcCapture));
        chk("shift", 32'h48EABCD2, rxShiftWord);
        for (int b = 0; b < 4; b++)
            u_crxsc_proto_model.field(32'(8'hAB + 8'(b * 8'h22)), 8, 1'b0,
                4'(4'h1 << b), (b == 3) ? 6 : 0, 0);
        @(posedge ref_clk);
        chk("bufWrite", 32'h1, 32'(rxBufWrite));
        chk("bufData", 32'h11EFCDAB, rxBufData);
        chk("bufIdx", 32'h0, 32'(rxBufWordIdx));
        @(posedge ref_clk);
        chk("bufDrop", 32'h0, 32'(rxBufWrite));
        chk("bufIdxNext", 32'h1, 32'(rxBufWordIdx));
        u_crxsc_proto_model.field(32'h5A, 8, 1'b0, 4'h1, 0, 2);
        u_crxsc_proto_model.field(32'hC3, 8, 1'b0, 4'h2, 6, 0);
        @(posedge ref_clk);
        chk("bufWrite", 32'h1, 32'(rxBufWrite));
        chk("bufData", 32'h11EFC35A, rxBufData);
        chk("bufIdx", 32'h1, 32'(rxBufWordIdx));
        u_crxsc_proto_model.field(32'hB, 4, 1'b1, 4'hF, 4, 0);
        @(posedge ref_clk);
        chk("stuff", 32'hB, 32'(stuffCountCapture));
        u_crxsc_proto_model.field(32'h1A5A5, 17, 1'b1, 4'hF, 5, 0);
        u_crxsc_proto_model.field(32'hFF, 8, 1'b1, 4'hF, 0, 1);
        wbGo(1'b0, CRXSC_OFS_SHIFT, 32'h0, 32'h6B57A5A5);
        wbGo(1'b0, CRXSC_OFS_STATUS, 32'h0, 32'h215);
        wbGo(1'b0, CRXSC_OFS_META, 32'h0, 32'hB02);
        wbGo(1'b0, CRXSC_OFS_BASE_ID, 32'h0, 32'h123);
        wbGo(1'b0, CRXSC_OFS_EXT_ID, 32'h0, 32'h2ABCD);
        u_crxsc_proto_model.sof();
        wbGo(1'b0, CRXSC_OFS_STATUS, 32'h0, 32'h014);
        u_crxsc_proto_model.field(32'h5, 4, 1'b1, 4'hF, 0, 0);
        @(posedge ref_clk);
        chk("shift", 32'hB57A5A55, rxShiftWord);
        wbGo(1'b1, CRXSC_OFS_CTRL, 32'h0, 32'h0);
        u_crxsc_proto_model.field(32'hF, 4, 1'b1, 4'hF, 0, 0);
        @(posedge ref_clk);
        chk("shiftOff", 32'hB57A5A55, rxShiftWord);
        wbGo(1'b1, CRXSC_OFS_CTRL, 32'h3, 32'h0);
        wbGo(1'b0, CRXSC_OFS_CTRL, 32'h0, 32'h1);
        chk("shiftClr", 32'h0, rxShiftWord);
        chk("baseClr", 32'h0, 32'(baseIdCapture));
        chk("extClr", 32'h0, 32'(extIdCapture));
        printVerdict();
    end
endmodule

`default_nettype wire
